// ### hdl/pcit_top.sv
// three channel interval timer with its i/o ports, port b and clock select
`timescale 1ns/1ps
module pcit_top
  import pcit_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire pcit_io_req_s io_req_i,
  output logic [7:0]        io_rdata_o,
  input  wire logic         external_count_clock_pin_i,
  input  wire logic         ch2_gate_pin_i,
  input  wire logic         ch2_gate_pin_func_i,
  input  wire logic         system_tick_steer_i,
  output logic              ch2_output_pin_o,
  output logic [2:0]        timer_irq_o,
  output logic              system_tick_interrupt_o
);

  pcit_state_s q;
  pcit_state_s d;
  logic        tick;
  logic        gate2;
  logic        gate2_rise;
  logic [2:0]  gate;
  logic [2:0]  rise;

  // aliases 6 and 7 fold onto modes 2 and 3
  function automatic pcit_mode_e fold_mode(input logic [2:0] m);
    logic [2:0] r;
    r = m;
    if (m[2:1] == 2'b11) begin
      r = {1'b0, m[1:0]};
    end
    return pcit_mode_e'(r);
  endfunction

  // behaviour of one channel at a count clock tick
  function automatic pcit_ch_s ch_tick(input pcit_ch_s c, input logic g);
    pcit_ch_s n;
    logic     hw_start;
    logic     nxt_out;
    n        = c;
    hw_start = c.trig & c.ready;
    nxt_out  = ~c.out;
    case (c.mode)
      MODE_TC: begin
        if (c.load_pend) begin
          n.cnt       = c.init;
          n.load_pend = 1'b0;
          n.armed     = 1'b1;
        end else if (c.armed && g) begin
          n.cnt = c.cnt - 16'h0001;
          if (c.cnt == 16'h0001) begin
            n.out   = 1'b1;
            n.armed = 1'b0;
          end
        end
      end
      MODE_ONESHOT: begin
        if (hw_start) begin
          n.cnt   = c.init;
          n.out   = 1'b0;
          n.armed = 1'b1;
          n.trig  = 1'b0;
        end else if (c.armed) begin
          n.cnt = c.cnt - 16'h0001;
          if (c.cnt == 16'h0001) begin
            n.out   = 1'b1;
            n.armed = 1'b0;
          end
        end
      end
      MODE_RATE: begin
        if (c.load_pend) begin
          n.cnt       = c.init;
          n.load_pend = 1'b0;
          n.armed     = 1'b1;
          n.out       = 1'b1;
        end else if (c.armed && g) begin
          if (c.cnt == 16'h0002) begin
            n.cnt = 16'h0001;
            n.out = 1'b0;
          end else if (c.cnt == 16'h0001) begin
            n.cnt = c.init;
            n.out = 1'b1;
          end else begin
            n.cnt = c.cnt - 16'h0001;
          end
        end
      end
      MODE_SQUARE: begin
        if (c.load_pend) begin
          n.cnt       = c.init + {15'h0000, c.init[0]};
          n.load_pend = 1'b0;
          n.armed     = 1'b1;
          n.out       = 1'b1;
        end else if (c.armed && g) begin
          if (c.cnt == 16'h0002) begin
            n.out = nxt_out;
            // odd counts give the high half one more clock than the low half
            if (nxt_out) begin
              n.cnt = c.init + {15'h0000, c.init[0]};
            end else begin
              n.cnt = c.init - {15'h0000, c.init[0]};
            end
          end else begin
            n.cnt = c.cnt - 16'h0002;
          end
        end
      end
      MODE_SW_STROBE, MODE_HW_STROBE: begin
        if ((c.mode == MODE_SW_STROBE) ? c.load_pend : hw_start) begin
          n.cnt       = c.init;
          n.load_pend = 1'b0;
          n.trig      = 1'b0;
          n.armed     = 1'b1;
          n.out       = 1'b1;
        end else if (!c.out) begin
          n.out = 1'b1;
        end else if (c.armed && g) begin
          n.cnt = c.cnt - 16'h0001;
          if (c.cnt == 16'h0001) begin
            n.out   = 1'b0;
            n.armed = 1'b0;
          end
        end
      end
      default: begin
        n = c;
      end
    endcase
    return n;
  endfunction

  // new control word for one channel
  function automatic pcit_ch_s ch_control(input pcit_ch_s c, input logic [7:0] w,
                                          input logic may_trigger);
    pcit_ch_s   n;
    pcit_mode_e m;
    n = c;
    m = fold_mode(w[CW_MODE_LO +: 3]);
    if (pcit_rw_e'(w[CW_RW_LO +: 2]) == RW_LATCH) begin
      if (!c.latched) begin
        n.latched = 1'b1;
        n.latch   = c.cnt;
      end
    end else if (may_trigger || (m != MODE_ONESHOT && m != MODE_HW_STROBE)) begin
      n.mode      = m;
      n.rwm       = pcit_rw_e'(w[CW_RW_LO +: 2]);
      n.out       = (m != MODE_TC);
      n.armed     = 1'b0;
      n.load_pend = 1'b0;
      n.ready     = 1'b0;
      n.trig      = 1'b0;
      n.wr_msb    = 1'b0;
      n.rd_msb    = 1'b0;
      n.latched   = 1'b0;
    end
    return n;
  endfunction

  // one byte written to a count port
  function automatic pcit_ch_s ch_write(input pcit_ch_s c, input logic [7:0] b);
    pcit_ch_s n;
    logic     done;
    n    = c;
    done = 1'b1;
    case (c.rwm)
      RW_LSB: begin
        n.init = {8'h00, b};
      end
      RW_MSB: begin
        n.init = {b, 8'h00};
      end
      RW_BOTH: begin
        if (!c.wr_msb) begin
          n.wr_lo  = b;
          n.wr_msb = 1'b1;
          done     = 1'b0;
        end else begin
          n.init   = {b, c.wr_lo};
          n.wr_msb = 1'b0;
        end
      end
      default: begin
        done = 1'b0;
      end
    endcase
    if (done) begin
      n.load_pend = 1'b1;
      n.ready     = 1'b1;
      if (c.mode == MODE_TC) begin
        n.out   = 1'b0;
        n.armed = 1'b0;
      end
    end
    return n;
  endfunction

  // byte read back from a count port, latched value first
  function automatic logic [7:0] ch_read_byte(input pcit_ch_s c);
    logic [15:0] v;
    logic [7:0]  r;
    v = c.latched ? c.latch : c.cnt;
    r = v[7:0];
    if (c.rwm == RW_MSB || (c.rwm == RW_BOTH && c.rd_msb)) begin
      r = v[15:8];
    end
    return r;
  endfunction

  function automatic pcit_ch_s ch_read(input pcit_ch_s c);
    pcit_ch_s n;
    n = c;
    if (c.rwm == RW_BOTH) begin
      n.rd_msb = ~c.rd_msb;
    end
    if (c.rwm != RW_BOTH || c.rd_msb) begin
      n.latched = 1'b0;
    end
    return n;
  endfunction

  pcit_tick_gen u_tick (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_dir_i  (q.pin_dir),
    .ext_clk_i  (external_count_clock_pin_i),
    .tick_o     (tick)
  );

  // pin gate joins the soft bit only while the pin function is selected
  assign gate2 = q.soft_gate | (ch2_gate_pin_func_i & ch2_gate_pin_i);

  pcit_rise_det u_gate2 (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .level_i    (gate2),
    .rise_o     (gate2_rise)
  );

  assign gate = {gate2, 1'b1, 1'b1};
  assign rise = {gate2_rise, 1'b0, 1'b0};

  always_comb begin
    logic [1:0] idx;
    logic [7:0] r;
    d   = q;
    idx = 2'(io_req_i.addr - ADDR_CH0);
    r   = 8'h00;

    for (int i = 0; i < 3; i++) begin
      if (tick) begin
        d.ch[i] = ch_tick(q.ch[i], gate[i]);
      end
      // an edge in the tick that consumes the last one stays pending
      if (rise[i]) begin
        d.ch[i].trig = 1'b1;
      end
    end

    if (io_req_i.wr) begin
      case (io_req_i.addr)
        ADDR_CH0, ADDR_CH1, ADDR_CH2: begin
          d.ch[idx] = ch_write(d.ch[idx], io_req_i.wdata);
        end
        ADDR_MODE: begin
          if (io_req_i.wdata[CW_SEL_LO +: 2] != SEL_READBACK) begin
            idx = io_req_i.wdata[CW_SEL_LO +: 2];
            d.ch[idx] = ch_control(d.ch[idx], io_req_i.wdata, idx == 2'd2);
          end
        end
        ADDR_PORTB: begin
          d.soft_gate = io_req_i.wdata[PB_SOFT_GATE];
          d.out_en    = io_req_i.wdata[PB_OUT_EN];
        end
        ADDR_CLOCK_SOURCE_SELECT: begin
          d.pin_dir = io_req_i.wdata[CS_PIN_DIR];
        end
        default: begin
          d.pin_dir = d.pin_dir;
        end
      endcase
    end

    if (io_req_i.rd) begin
      case (io_req_i.addr)
        ADDR_CH0, ADDR_CH1, ADDR_CH2: begin
          r         = ch_read_byte(q.ch[idx]);
          d.ch[idx] = ch_read(d.ch[idx]);
        end
        ADDR_PORTB: begin
          r[PB_SOFT_GATE] = q.soft_gate;
          r[PB_OUT_EN]    = q.out_en;
          r[PB_OUT_STA]   = q.ch[2].out;
        end
        ADDR_CLOCK_SOURCE_SELECT: begin
          r[CS_PIN_DIR] = q.pin_dir;
        end
        default: begin
          r = 8'h00;
        end
      endcase
      d.rdata = r;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q           <= '0;
      q.soft_gate <= SOFT_GATE_RST;
      q.out_en    <= OUT_EN_RST;
      q.pin_dir   <= PIN_DIR_RST;
      q.rdata     <= RDATA_RST;
      for (int i = 0; i < 3; i++) begin
        q.ch[i].cnt  <= COUNT_RST;
        q.ch[i].init <= COUNT_RST;
        q.ch[i].out  <= CH_OUT_RST;
      end
    end else begin
      q <= d;
    end
  end

  assign io_rdata_o              = q.rdata;
  assign timer_irq_o             = {q.ch[2].out, q.ch[1].out, q.ch[0].out};
  assign system_tick_interrupt_o = q.ch[0].out & system_tick_steer_i;
  assign ch2_output_pin_o        = q.ch[2].out & q.out_en;

endmodule

// ### pkg/pcit_pkg.sv
// package: register map, field layout, timing and state types of the interval timer
package pcit_pkg;

  // i/o map of the timer
  localparam logic [11:0] ADDR_CH0        = 12'h040;
  localparam logic [11:0] ADDR_CH1        = 12'h041;
  localparam logic [11:0] ADDR_CH2        = 12'h042;
  localparam logic [11:0] ADDR_MODE       = 12'h043;
  localparam logic [11:0] ADDR_PORTB      = 12'h061;
  localparam logic [11:0] ADDR_CLOCK_SOURCE_SELECT     = 12'hc26;

  // control word fields
  localparam int          CW_SEL_LO       = 6;
  localparam int          CW_RW_LO        = 4;
  localparam int          CW_MODE_LO      = 1;
  localparam logic [1:0]  SEL_READBACK    = 2'h3;

  // system control port b and clock select bits
  localparam int          PB_SOFT_GATE    = 0;
  localparam int          PB_OUT_EN       = 1;
  localparam int          PB_OUT_STA      = 5;
  localparam int          CS_PIN_DIR      = 0;

  // reset values
  localparam logic        SOFT_GATE_RST   = 1'b0;
  localparam logic        OUT_EN_RST      = 1'b0;
  localparam logic        PIN_DIR_RST     = 1'b0;
  localparam logic [15:0] COUNT_RST       = 16'h0000;
  localparam logic        CH_OUT_RST      = 1'b0;
  localparam logic [7:0]  RDATA_RST       = 8'h00;

  // count clock derived from the core clock by a phase accumulator
  localparam int          CORE_CLK_HZ     = 10_000_000;
  localparam int          COUNT_CLK_HZ    = 1_189_200;
  localparam int          ACC_W           = 24;
  localparam logic [23:0] ACC_STEP        = 24'(COUNT_CLK_HZ);
  localparam logic [23:0] ACC_WRAP        = 24'(CORE_CLK_HZ);

  typedef enum logic [2:0] {
    MODE_TC        = 3'b000,
    MODE_ONESHOT   = 3'b001,
    MODE_RATE      = 3'b010,
    MODE_SQUARE    = 3'b011,
    MODE_SW_STROBE = 3'b100,
    MODE_HW_STROBE = 3'b101
  } pcit_mode_e;

  typedef enum logic [1:0] {
    RW_LATCH = 2'b00,
    RW_LSB   = 2'b01,
    RW_MSB   = 2'b10,
    RW_BOTH  = 2'b11
  } pcit_rw_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } pcit_io_req_s;

  typedef struct packed {
    pcit_mode_e  mode;
    pcit_rw_e    rwm;
    logic [15:0] cnt;
    logic [15:0] init;
    logic [15:0] latch;
    logic [7:0]  wr_lo;
    logic        out;
    logic        armed;
    logic        load_pend;
    logic        ready;
    logic        trig;
    logic        wr_msb;
    logic        rd_msb;
    logic        latched;
  } pcit_ch_s;

  typedef struct packed {
    pcit_ch_s [2:0] ch;
    logic           soft_gate;
    logic           out_en;
    logic           pin_dir;
    logic [7:0]     rdata;
  } pcit_state_s;

  typedef struct packed {
    logic [23:0] acc;
    logic        ext_prev;
    logic        tick;
  } pcit_tick_s;

endpackage

// ### hdl/pcit_rise_det.sv
// rising edge detector on a level sampled by the core clock
`timescale 1ns/1ps
module pcit_rise_det
  import pcit_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      rise_o
);

  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = level_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise_o = level_i & ~prev_q;

endmodule

// ### hdl/pcit_tick_gen.sv
// count clock enable: internal accumulator or rising edges of the external pin
`timescale 1ns/1ps
module pcit_tick_gen
  import pcit_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_dir_i,
  input  wire logic ext_clk_i,
  output logic      tick_o
);

  pcit_tick_s  q;
  pcit_tick_s  d;
  logic [23:0] sum;

  always_comb begin
    d   = q;
    sum = q.acc + ACC_STEP;
    d.tick = 1'b0;
    if (sum >= ACC_WRAP) begin
      d.acc = sum - ACC_WRAP;
      d.tick = ~pin_dir_i;
    end else begin
      d.acc = sum;
    end
    // the pin clock is only a few times slower than the core clock, so one edge is one tick
    d.ext_prev = ext_clk_i;
    if (pin_dir_i) begin
      d.tick = ext_clk_i & ~q.ext_prev;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;

endmodule

// ### verification/pcit_pic_model.sv
// interrupt controller stand-in: counts raised requests of channel 0
`timescale 1ns/1ps
module pcit_pic_model
  import pcit_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] irq_i,
  output logic [7:0]      ch0_rise_o
);
  logic prev_q;
  // only a low-to-high edge is a request; a held level is not counted again
  always_ff @(posedge core_clk_i) begin
    prev_q <= rst_i ? 1'b0 : irq_i[0];
    if (rst_i) begin
      ch0_rise_o <= 8'h00;
    end else if (irq_i[0] && !prev_q) begin
      ch0_rise_o <= ch0_rise_o + 8'h01;
    end
  end
endmodule

// ### verification/pcit_top_chk.sv
// checker: port-level properties of the interval timer
`timescale 1ns/1ps
module pcit_top_chk
  import pcit_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire pcit_io_req_s io_req_i,
  input  wire logic [7:0]   io_rdata_o,
  input  wire logic         system_tick_steer_i,
  input  wire logic         ch2_output_pin_o,
  input  wire logic [2:0]   timer_irq_o,
  input  wire logic         system_tick_interrupt_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic unmapped;
  assign unmapped = !(io_req_i.addr inside {ADDR_CH0, ADDR_CH1, ADDR_CH2, ADDR_PORTB,
                                             ADDR_CLOCK_SOURCE_SELECT});
  sequence rd_at(logic [11:0] a);
    io_req_i.rd && io_req_i.addr == a;
  endsequence
  sequence pb_wr(logic en);
    io_req_i.wr && io_req_i.addr == ADDR_PORTB && io_req_i.wdata[PB_OUT_EN] == en;
  endsequence
  sequence pb_wr_rd;
    io_req_i.wr && io_req_i.addr == ADDR_PORTB ##1 !io_req_i.wr ##1 rd_at(ADDR_PORTB);
  endsequence
  steer_and_a: assert property (system_tick_interrupt_o ==
    (timer_irq_o[0] && system_tick_steer_i)) else $error("system tick mismatch");
  pin_follow_a: assert property (ch2_output_pin_o |-> timer_irq_o[2])
    else $error("output pin without channel 2 output");
  pin_off_a: assert property (pb_wr(1'b0) |=> !ch2_output_pin_o)
    else $error("output pin driven while disabled");
  pin_on_a: assert property (pb_wr(1'b1) ##1 timer_irq_o[2] |-> ch2_output_pin_o)
    else $error("output pin not driven while enabled");
  rd_hold_a: assert property (!io_req_i.rd |=> $stable(io_rdata_o))
    else $error("read data moved without a read");
  unmapped_rd_a: assert property (io_req_i.rd && unmapped |=> io_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  clock_source_select_rd_a: assert property (rd_at(ADDR_CLOCK_SOURCE_SELECT) |=> io_rdata_o[7:1] == 7'h00)
    else $error("clock select spare bits set");
  portb_rd_a: assert property (rd_at(ADDR_PORTB) |=> io_rdata_o[5] == $past(timer_irq_o[2])
    && io_rdata_o[7:6] == 2'h0 && io_rdata_o[4:2] == 3'h0)
    else $error("port b status wrong");
  portb_back_a: assert property (pb_wr_rd |=>
    io_rdata_o[1:0] == $past(io_req_i.wdata[1:0], 3)) else $error("port b readback wrong");
endmodule

bind pcit_top pcit_top_chk chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .io_req_i(io_req_i), .io_rdata_o(io_rdata_o),
  .system_tick_steer_i(system_tick_steer_i), .ch2_output_pin_o(ch2_output_pin_o),
  .timer_irq_o(timer_irq_o), .system_tick_interrupt_o(system_tick_interrupt_o));

// ### verification/pcit_top_tb.sv
// testbench: host stimulus and queue-based checking of the interval timer
`timescale 1ns/1ps
module pcit_top_tb
  import pcit_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  pcit_io_req_s io = '0;
  logic [7:0]   rdata;
  logic         ext = 1'b0;
  logic         gpin = 1'b0;
  logic         gfunc = 1'b0;
  logic         steer = 1'b0;
  logic         opin;
  logic [2:0]   irq;
  logic         sti;
  logic [7:0]   edges;
  logic [7:0]   ov = 8'h00;
  logic         ochk = 1'b0;
  logic         rd_d = 1'b0;
  logic [7:0]   expq[$];
  logic [7:0]   e;
  int           bad_count = 0;
  int           n_checks = 0;
  int           n;
  int           hi;
  always #50 clk = ~clk;
  pcit_top dut (.core_clk_i(clk), .rst_i(rst), .io_req_i(io), .io_rdata_o(rdata),
    .external_count_clock_pin_i(ext), .ch2_gate_pin_i(gpin), .ch2_gate_pin_func_i(gfunc),
    .system_tick_steer_i(steer), .ch2_output_pin_o(opin), .timer_irq_o(irq),
    .system_tick_interrupt_o(sti));
  pcit_pic_model pic (.core_clk_i(clk), .rst_i(rst), .irq_i(irq), .ch0_rise_o(edges));
  // read data stands from one cycle after the read, so compare one edge later
  always @(posedge clk) begin
    rd_d <= io.rd;
    if (rd_d || ochk) begin
      e = expq.pop_front();
      n_checks++;
      if ((rd_d ? rdata : ov) !== e) begin
        bad_count++;
        $display("BAD %0t got %h want %h", $time, rd_d ? rdata : ov, e);
      end
    end
  end
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    io <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    io <= '0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] x);
    expq.push_back(x);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic ochk_v(input logic [7:0] v, input logic [7:0] x);
    expq.push_back(x);
    @(posedge clk);
    ov <= v;
    ochk <= 1'b1;
    @(posedge clk);
    ochk <= 1'b0;
  endtask
  // one pin clock; the tick lands a cycle later, outputs one more
  task automatic tick;
    @(posedge clk);
    ext <= 1'b1;
    repeat (3) @(posedge clk);
    ext <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // kind 0: high after n, 2: low every n-th, 4: low at n+1 only, 3: count highs
  task automatic run(input int ch, input logic [7:0] cw, input int kind, input logic [7:0] pb);
    acc(1'b1, ADDR_MODE, cw);
    acc(1'b1, ADDR_CH0 + 12'(ch), 8'(n));
    if (cw[5:4] == 2'h3) acc(1'b1, ADDR_CH0 + 12'(ch), 8'h00);
    if (pb == 8'hfe) begin
      @(posedge clk);
      gpin <= 1'b1;
    end else if (pb != 8'hff) acc(1'b1, ADDR_PORTB, pb);
    hi = 0;
    for (int k = 1; k <= 2 * n + 2; k++) begin
      tick();
      if (kind == 3) hi += (k > 1 && k <= 2 * n + 1 && irq[ch] === 1'b1) ? 1 : 0;
      else ochk_v({7'h0, irq[ch]},
                  {7'h0, kind == 2 ? k % n != 0 : kind == 4 ? k != n + 1 : k > n});
    end
    if (kind == 3) ochk_v(8'(hi), 8'(n + 1));
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
  initial begin
    void'($urandom(27939));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ADDR_PORTB, 8'h00);
    rd_chk(ADDR_CLOCK_SOURCE_SELECT, 8'h00);
    rd_chk(ADDR_MODE, 8'h00);
    rd_chk(12'h123, 8'h00);
    acc(1'b1, ADDR_PORTB, 8'hfe);
    rd_chk(ADDR_PORTB, 8'h02);
    acc(1'b1, ADDR_CLOCK_SOURCE_SELECT, 8'h01);
    rd_chk(ADDR_CLOCK_SOURCE_SELECT, 8'h01);
    $display("test registers done");
    n = 2 + $urandom % 4;
    steer <= 1'b1;
    run(0, 8'h10, 0, 8'hff);
    ochk_v(edges, 8'h01);
    steer <= 1'b0;
    acc(1'b1, ADDR_MODE, 8'h12);
    tick();
    ochk_v({7'h0, irq[0]}, 8'h01);
    // a refused mode 1 word must leave mode 0, so a new count drives the output low
    acc(1'b1, ADDR_CH0, 8'h2b);
    tick();
    ochk_v({7'h0, irq[0]}, 8'h00);
    acc(1'b1, ADDR_MODE, 8'h34);
    acc(1'b1, ADDR_CH0, 8'h2b);
    acc(1'b1, ADDR_CH0, 8'hff);
    tick();
    rd_chk(ADDR_CH0, 8'h2b);
    rd_chk(ADDR_CH0, 8'hff);
    $display("test mode 0 done");
    n = 2 + $urandom % 4;
    run(1, 8'h74, 2, 8'hff);
    $display("test mode 2 done");
    n = 5;
    acc(1'b1, ADDR_PORTB, 8'h03);
    run(2, 8'h96, 3, 8'hff);
    n = 2 + $urandom % 4;
    run(2, 8'h98, 4, 8'hff);
    rd_chk(ADDR_PORTB, 8'h23);
    ochk_v({7'h0, opin}, 8'h01);
    $display("test modes 3 4 done");
    acc(1'b1, ADDR_PORTB, 8'h02);
    run(2, 8'h92, 0, 8'h03);
    // start a pulse, retrigger it after two ticks: low must last n ticks from the retrigger
    acc(1'b1, ADDR_PORTB, 8'h02);
    acc(1'b1, ADDR_PORTB, 8'h03);
    tick();
    tick();
    acc(1'b1, ADDR_PORTB, 8'h02);
    acc(1'b1, ADDR_PORTB, 8'h03);
    for (int k = 1; k <= n + 1; k++) begin
      tick();
      ochk_v({7'h0, irq[2]}, {7'h0, k > n});
    end
    acc(1'b1, ADDR_PORTB, 8'h00);
    // the enable lands at the write edge, so look one edge later
    @(posedge clk);
    ochk_v({6'h0, opin, irq[2]}, 8'h01);
    gfunc <= 1'b1;
    run(2, 8'h9a, 4, 8'hfe);
    $display("test modes 1 5 done");
    // let the last queued compare happen before the verdict
    repeat (2) @(posedge clk);
    results();
  end
endmodule
